// ==== bench/rls_radio_model.sv ====
// Behavioural radio front end raising detector and fifo events on command
`timescale 1ns/1ps
`default_nettype none

module rls_radio_model
  import rls_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire rls_events_t cmd,
  input wire logic [15:0] len,
  output var rls_events_t ev
);
  // ****************************************************************
  // Event source
  // ****************************************************************
  logic [15:0] left_reg;

  // Hold the commanded events for len cycles, then drop all lines low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev <= '0;
      left_reg <= 16'h0000;
    end else if (go) begin
      ev <= cmd;
      left_reg <= len;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
      if (left_reg == 16'h0001) ev <= '0;
    end
  end
endmodule : rls_radio_model
`default_nettype wire

// ==== bench/rls_sequencer_chk.sv ====
// Concurrent checks on the listen sequencer ports
`timescale 1ns/1ps
`default_nettype none

module rls_sequencer_chk
  import rls_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic preamble_found_event,
  input wire logic sync_match_event,
  input wire logic rx_on,
  input wire logic rc_osc_only,
  input wire logic seq_active,
  input wire logic [4:0] event_pins,
  input wire logic irq
);
  // ****************************************************************
  // Shadow settings and run-length counters
  // ****************************************************************
  logic [8:0] cfg_reg;
  logic [10:0] pm_reg;
  logic [15:0] tmr1_reg;
  logic [15:0] t2_reg;
  int idle_cnt_reg;
  int rx_cnt_reg;
  logic wstart;

  assign wstart = reg_wr && reg_addr == RLS_ADDR_CTRL && reg_wdata[RLS_CTRL_START];

  // Follow software writes so the bounds track the live settings
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= RLS_CFG_RESET;
      pm_reg <= RLS_PINMAP_RESET;
      tmr1_reg <= RLS_TMR1_RESET;
      t2_reg <= RLS_T2_RESET;
    end else if (reg_wr) begin
      if (reg_addr == RLS_ADDR_CFG) cfg_reg <= reg_wdata[8:0];
      if (reg_addr == RLS_ADDR_PINMAP) pm_reg <= reg_wdata[10:0];
      if (reg_addr == RLS_ADDR_TMR1) tmr1_reg <= reg_wdata;
      if (reg_addr == RLS_ADDR_T2) t2_reg <= reg_wdata;
    end
  end

  // Run lengths; long windows are counted here, too long to unroll
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_reg <= 0;
      rx_cnt_reg <= 0;
    end else begin
      idle_cnt_reg <= rc_osc_only ? idle_cnt_reg + 1 : 0;
      rx_cnt_reg <= (rx_on && seq_active) ? rx_cnt_reg + 1 : 0;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_rdata_quiet; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("Read data without read");
  property p_sleep_dry; rc_osc_only |-> !rx_on; endproperty
  a_sleep_dry: assert property (p_sleep_dry) else $error("Receiver on in sleep");
  property p_idle_len; idle_cnt_reg <= (tmr1_reg + t2_reg) * RLS_TICK_CYCLES + 8; endproperty
  a_idle_len: assert property (p_idle_len) else $error("Idle too long");
  property p_rx_len; rx_cnt_reg <= t2_reg * RLS_TICK_CYCLES + 8; endproperty
  a_rx_len: assert property (p_rx_len) else $error("Receive window too long");
  property p_back_idle;
    $fell(rx_on) && seq_active && !$past(reg_wr) |-> ##[0:2] rc_osc_only;
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("No sleep after window");
  property p_pre_stop;
    $rose(preamble_found_event) && rx_on && seq_active &&
      cfg_reg[7:5] == RLS_RXEXIT_ON_PREAMBLE |-> ##[2:6] (rx_on && !seq_active);
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("Preamble did not stop");
  property p_sync_stop;
    $rose(sync_match_event) && rx_on && seq_active &&
      cfg_reg[7:5] == RLS_RXEXIT_ON_SYNC |-> ##[2:6] (rx_on && !seq_active);
  endproperty
  a_sync_stop: assert property (p_sync_stop) else $error("Sync did not stop");
  property p_hold; rx_on && !seq_active && !reg_wr && !$past(reg_wr) |=> rx_on; endproperty
  a_hold: assert property (p_hold) else $error("Receiver left hold");
  property p_no_resume; !seq_active && !wstart && !$past(wstart) |=> !seq_active; endproperty
  a_no_resume: assert property (p_no_resume) else $error("Polling resumed alone");
  property p_pin4;
    $rose(preamble_found_event) && pm_reg[10:8] == 3'h7 |-> ##[1:5] event_pins[4];
  endproperty
  a_pin4: assert property (p_pin4) else $error("Preamble pin not raised");
  property p_mask_off;
    reg_wr && reg_addr == RLS_ADDR_IRQ_MASK && reg_wdata == 16'h0000 |-> ##[1:3] !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("Masked interrupt still high");
endmodule : rls_sequencer_chk

bind rls_sequencer rls_sequencer_chk u_chk (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .preamble_found_event(preamble_found_event), .sync_match_event(sync_match_event),
  .rx_on(rx_on), .rc_osc_only(rc_osc_only), .seq_active(seq_active),
  .event_pins(event_pins), .irq(irq)
);
`default_nettype wire

// ==== bench/rls_sequencer_test.sv ====
// Self-checking testbench for the radio listen sequencer
`timescale 1ns/1ps
`default_nettype none

module rls_sequencer_test
  import rls_pkg::*;
;
  // ****************************************************************
  // Signals and tables
  // ****************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [15:0] len = 16'h0000;
  rls_events_t cmd = '0;
  rls_events_t ev;
  logic [15:0] reg_rdata;
  logic rx_on;
  logic rc_osc_only;
  logic seq_active;
  logic [4:0] event_pins;
  logic irq;
  logic rd_d = 1'b0;
  logic [7:0] seed = 8'h28;
  logic [15:0] exp_q [$];
  logic [15:0] rst [6] = '{16'h00C7, 16'h0064, 16'h0064, 16'h0010, 16'h0000, 16'h0000};
  logic [15:0] cfgs [3] = '{16'h00C7, 16'h00A7, 16'h0087};
  logic [15:0] stat [3] = '{16'h0001, 16'h0003, 16'h0004};
  logic [4:0] pins [3] = '{5'h10, 5'h14, 5'h00};
  int n_errors = 0;
  int cmp_count = 0;

  rls_sequencer DUT (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .preamble_found_event(ev.preamble), .sync_match_event(ev.sync),
    .payload_complete_event(ev.payload), .crc_pass(ev.crc),
    .fifo_threshold(ev.fifo_threshold), .fifo_drained(ev.fifo_drained),
    .rx_on(rx_on), .rc_osc_only(rc_osc_only), .seq_active(seq_active),
    .event_pins(event_pins), .irq(irq)
  );
  rls_radio_model u_radio (
    .clk(clk), .resetn(resetn), .go(go), .cmd(cmd), .len(len), .ev(ev)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Window lengths drift by a few cycles of synchroniser delay
  task automatic cmp_rng(input int got, input int exp);
    cmp_count++;
    if (got < exp - 8 || got > exp + 8) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_rng

  task automatic chk_lv(input logic [2:0] e);
    cmp({13'h0, rx_on, rc_osc_only, seq_active}, {13'h0, e});
  endtask : chk_lv

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // The expected word is queued now and compared when the data appear
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic fire(input rls_events_t e, input logic [15:0] n);
    @(posedge clk);
    cmd <= e;
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : fire

  // Bounded wait for the receiver level; a timeout counts as a mismatch
  task automatic wait_rx(input logic v, output int n);
    n = 0;
    while (rx_on !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    cmp({15'h0, rx_on}, {15'h0, v});
  endtask : wait_rx

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Read data are valid in the cycle after the strobe only
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) cmp(reg_rdata, exp_q.pop_front());
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin : main
    int n;
    rls_events_t e;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 1; a < 7; a++) rd(4'(a), rst[a - 1]);
    seed = lfsr(seed);
    wr(4'hF, {8'h00, seed});
    rd(4'hF, 16'h0000);
    wr(RLS_ADDR_TMR1, 16'h0002);
    wr(RLS_ADDR_T2, 16'h0002);
    wr(RLS_ADDR_IRQ_MASK, 16'h0007);
    wr(RLS_ADDR_PINMAP, 16'h0731);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      e = '0;
      e.crc = seed[0];
      e.fifo_threshold = seed[1];
      e.fifo_drained = seed[2];
      fire(e, 16'h0010);
      repeat (6) @(posedge clk);
      cmp({11'h0, event_pins}, {12'h0, e.fifo_drained, 1'b0, e.fifo_threshold, e.crc});
    end
    // Listening with no signal: sleep, window, sleep again
    wr(RLS_ADDR_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    chk_lv(3'b011);
    rd(RLS_ADDR_STATE, 16'h0001);
    wait_rx(1'b1, n);
    wait_rx(1'b0, n);
    cmp_rng(n, 1280);
    repeat (3) @(posedge clk);
    chk_lv(3'b011);
    wait_rx(1'b1, n);
    cmp_rng(n + 3, 1280);
    rd(RLS_ADDR_IRQ_STAT, 16'h0008);
    cmp({15'h0, irq}, 16'h0000);
    wr(RLS_ADDR_IRQ_MASK, 16'h000F);
    repeat (3) @(posedge clk);
    cmp({15'h0, irq}, 16'h0001);
    wr(RLS_ADDR_IRQ_STAT, 16'h0008);
    repeat (3) @(posedge clk);
    cmp({15'h0, irq}, 16'h0000);
    wr(RLS_ADDR_CTRL, 16'h0002);
    // Each wake condition in turn, then a long hold until stop
    for (int i = 0; i < 3; i++) begin
      wr(RLS_ADDR_CFG, cfgs[i]);
      wr(RLS_ADDR_CTRL, 16'h0001);
      wait_rx(1'b1, n);
      wr(RLS_ADDR_IRQ_STAT, 16'h000F);
      e = '0;
      e.preamble = (i != 2);
      e.sync = (i == 1);
      e.payload = (i == 2);
      fire(e, (i == 2) ? 16'h0010 : 16'h0F00);
      repeat (8) @(posedge clk);
      chk_lv(3'b100);
      cmp({11'h0, event_pins}, {11'h0, pins[i]});
      rd(RLS_ADDR_IRQ_STAT, stat[i]);
      cmp({15'h0, irq}, 16'h0001);
      // Long enough for the held preamble to drop before the next pass
      repeat (4000) @(posedge clk);
      rd(RLS_ADDR_STATE, 16'h0004);
      wr(RLS_ADDR_CTRL, 16'h0002);
      rd(RLS_ADDR_STATE, 16'h0000);
      chk_lv(3'b000);
    end
    // Sync listening with a short receive timeout
    wr(RLS_ADDR_RXTO, 16'h0001);
    wr(RLS_ADDR_CFG, 16'h01A7);
    wr(RLS_ADDR_CTRL, 16'h0001);
    wait_rx(1'b1, n);
    wait_rx(1'b0, n);
    cmp_rng(n, 640);
    wait_rx(1'b1, n);
    cmp_rng(n, 1920);
    e = '0;
    e.preamble = 1'b1;
    fire(e, 16'h0010);
    wait_rx(1'b0, n);
    cmp_rng(n, 1278);
    repeat (3) @(posedge clk);
    chk_lv(3'b011);
    wr(RLS_ADDR_CTRL, 16'h0002);
    wr(RLS_ADDR_IRQ_MASK, 16'h0000);
    repeat (3) @(posedge clk);
    cmp({15'h0, irq}, 16'h0000);
    // Shallow idle, standby target, and a start code that must do nothing
    for (int j = 0; j < 3; j++) begin
      wr(RLS_ADDR_CFG, (j == 0) ? 16'h00C6 : (j == 1) ? 16'h00C5 : 16'h00CF);
      wr(RLS_ADDR_CTRL, 16'h0001);
      rd(RLS_ADDR_STATE, 16'((j + 1) % 3));
      chk_lv({2'b00, j != 2});
      wr(RLS_ADDR_CTRL, 16'h0002);
    end
    repeat (4) @(posedge clk);
    tally_and_finish();
  end

  // Whole run is near 25000 cycles; this limit leaves ample margin
  initial begin : watchdog
    #6000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : rls_sequencer_test
`default_nettype wire

// ==== rtl/rls_pkg.sv ====
// Package of constants and types for the radio listen sequencer
package rls_pkg;

  // ****************************************************************
  // Register map (word addresses on the plain register port)
  // ****************************************************************
  localparam logic [3:0] RLS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] RLS_ADDR_CFG = 4'h1;
  localparam logic [3:0] RLS_ADDR_TMR1 = 4'h2;
  localparam logic [3:0] RLS_ADDR_T2 = 4'h3;
  localparam logic [3:0] RLS_ADDR_RXTO = 4'h4;
  localparam logic [3:0] RLS_ADDR_STATE = 4'h5;
  localparam logic [3:0] RLS_ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] RLS_ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] RLS_ADDR_PINMAP = 4'h8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RLS_CTRL_START = 0;
  localparam int RLS_CTRL_STOP = 1;
  localparam int RLS_CFG_IDLE_DEPTH = 0;
  localparam int RLS_CFG_LOW_POWER = 1;
  localparam int RLS_CFG_IDLE_EXIT = 2;
  localparam int RLS_CFG_START_LSB = 3;
  localparam int RLS_CFG_RXEXIT_LSB = 5;
  localparam int RLS_CFG_RXTO_EN = 8;
  localparam int RLS_PIN_PREAMBLE_SEL = 10;
  localparam int RLS_IRQ_PREAMBLE = 0;
  localparam int RLS_IRQ_SYNC = 1;
  localparam int RLS_IRQ_PAYLOAD = 2;
  localparam int RLS_IRQ_TMR1 = 3;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [8:0] RLS_CFG_RESET = 9'h0C7;
  localparam logic [15:0] RLS_TMR1_RESET = 16'h0064;
  localparam logic [15:0] RLS_T2_RESET = 16'h0064;
  localparam logic [15:0] RLS_RXTO_RESET = 16'h0010;
  localparam logic [10:0] RLS_PINMAP_RESET = 11'h0000;
  localparam logic [1:0] RLS_START_TO_LOW_POWER = 2'h0;
  localparam logic [2:0] RLS_RXEXIT_ON_PREAMBLE = 3'h6;
  localparam logic [2:0] RLS_RXEXIT_ON_SYNC = 3'h5;
  localparam logic [2:0] RLS_RXEXIT_ON_PAYLOAD = 3'h4;
  localparam logic [1:0] RLS_MAP_PREAMBLE = 2'h3;
  localparam logic [1:0] RLS_MAP_CRC_PASS = 2'h1;
  localparam logic [1:0] RLS_MAP_FIFO = 2'h0;
  localparam logic [1:0] RLS_MAP_SYNC = 2'h3;

  // ****************************************************************
  // Timing: timer tick is the 64 us timer resolution
  // ****************************************************************
  localparam int RLS_CLK_PERIOD_NS = 100;
  localparam int RLS_TICK_NS = 64000;
  localparam int RLS_TICK_CYCLES = RLS_TICK_NS / RLS_CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    RLS_ST_OFF = 3'b000,
    RLS_ST_IDLE = 3'b001,
    RLS_ST_STANDBY = 3'b010,
    RLS_ST_RX = 3'b011,
    RLS_ST_RX_HOLD = 3'b100
  } rls_state_t;

  typedef struct packed {
    logic preamble;
    logic sync;
    logic payload;
    logic crc;
    logic fifo_threshold;
    logic fifo_drained;
  } rls_events_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rls_bus_req_t;

endpackage : rls_pkg

// ==== rtl/rls_sequencer.sv ====
// Listen mode top sequencer with register port, interrupt and event pin mapping
`timescale 1ns/1ps
`default_nettype none

module rls_sequencer
  import rls_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic preamble_found_event,
  input wire logic sync_match_event,
  input wire logic payload_complete_event,
  input wire logic crc_pass,
  input wire logic fifo_threshold,
  input wire logic fifo_drained,
  output logic rx_on,
  output logic rc_osc_only,
  output logic seq_active,
  output logic [4:0] event_pins,
  output logic irq
);

  // ****************************************************************
  // Input synchronisers: radio events arrive from outside this domain
  // ****************************************************************
  rls_events_t ev_meta_reg;
  rls_events_t ev_sync_reg;
  rls_events_t ev_prev_reg;
  rls_events_t ev_rise;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
      ev_prev_reg <= '0;
    end else begin
      ev_meta_reg <= {preamble_found_event, sync_match_event, payload_complete_event,
                      crc_pass, fifo_threshold, fifo_drained};
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  // Events count on their rising edge so a held level fires once
  assign ev_rise = ev_sync_reg & ~ev_prev_reg;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [8:0] cfg_reg;
  logic [15:0] tmr1_reg;
  logic [15:0] t2_reg;
  logic [15:0] rxto_reg;
  logic [10:0] pinmap_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_stat_reg;
  logic start_req;
  logic stop_req;

  logic [1:0] start_code;
  logic [2:0] rxexit_code;
  assign start_code = cfg_reg[RLS_CFG_START_LSB +: 2];
  assign rxexit_code = cfg_reg[RLS_CFG_RXEXIT_LSB +: 3];

  assign start_req = reg_wr && (reg_addr == RLS_ADDR_CTRL) && reg_wdata[RLS_CTRL_START];
  assign stop_req = reg_wr && (reg_addr == RLS_ADDR_CTRL) && reg_wdata[RLS_CTRL_STOP];

  // Writable settings; writes to unmapped addresses are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= RLS_CFG_RESET;
      tmr1_reg <= RLS_TMR1_RESET;
      t2_reg <= RLS_T2_RESET;
      rxto_reg <= RLS_RXTO_RESET;
      pinmap_reg <= RLS_PINMAP_RESET;
      irq_mask_reg <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == RLS_ADDR_CFG) begin
        cfg_reg <= reg_wdata[8:0];
      end else if (reg_addr == RLS_ADDR_TMR1) begin
        tmr1_reg <= reg_wdata;
      end else if (reg_addr == RLS_ADDR_T2) begin
        t2_reg <= reg_wdata;
      end else if (reg_addr == RLS_ADDR_RXTO) begin
        rxto_reg <= reg_wdata;
      end else if (reg_addr == RLS_ADDR_PINMAP) begin
        pinmap_reg <= reg_wdata[10:0];
      end else if (reg_addr == RLS_ADDR_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Timer tick prescaler (RC oscillator time base)
  // ****************************************************************
  logic [9:0] pre_reg;
  logic tick;
  assign tick = (pre_reg == 10'(RLS_TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 10'h000;
    end else if (tick) begin
      pre_reg <= 10'h000;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // ****************************************************************
  // Sequencer state machine
  // ****************************************************************
  rls_state_t state_reg;
  rls_state_t state_next;
  logic [15:0] tmr_reg;
  logic [15:0] rxto_cnt_reg;
  logic preamble_seen_reg;
  logic tmr_done;
  logic rxto_done;
  logic wake_hit;
  logic rxto_exit;

  assign tmr_done = tick && (tmr_reg <= 16'h0001);
  assign rxto_done = cfg_reg[RLS_CFG_RXTO_EN] && tick && (rxto_cnt_reg <= 16'h0001);
  // A window cut short by the receive timeout must not shorten the poll
  // period, so the sleep that follows also takes the unused second timer
  assign rxto_exit = (state_reg == RLS_ST_RX) && !wake_hit && rxto_done && !preamble_seen_reg;

  // Which event ends the receive window with the sequencer off
  function automatic logic rx_exit_hit(input logic [2:0] code, input rls_events_t ev);
    rx_exit_hit = ((code == RLS_RXEXIT_ON_PREAMBLE) && ev.preamble)
               || ((code == RLS_RXEXIT_ON_SYNC) && ev.sync)
               || ((code == RLS_RXEXIT_ON_PAYLOAD) && ev.payload);
  endfunction : rx_exit_hit

  assign wake_hit = rx_exit_hit(rxexit_code, ev_rise);

  // Low power target: idle state when set, else sequencer waits in standby
  function automatic rls_state_t low_power_state(input logic sel);
    low_power_state = sel ? RLS_ST_IDLE : RLS_ST_STANDBY;
  endfunction : low_power_state

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RLS_ST_OFF: begin
        // Only a host start leaves off, never an event
        if (start_req && (start_code == RLS_START_TO_LOW_POWER)) begin
          state_next = low_power_state(cfg_reg[RLS_CFG_LOW_POWER]);
        end
      end
      RLS_ST_IDLE, RLS_ST_STANDBY: begin
        if (tmr_done && cfg_reg[RLS_CFG_IDLE_EXIT]) begin
          state_next = RLS_ST_RX;
        end
      end
      RLS_ST_RX: begin
        if (wake_hit) begin
          state_next = RLS_ST_RX_HOLD;
        end else if (rxto_done && !preamble_seen_reg) begin
          state_next = low_power_state(cfg_reg[RLS_CFG_LOW_POWER]);
        end else if (tmr_done) begin
          state_next = low_power_state(cfg_reg[RLS_CFG_LOW_POWER]);
        end
      end
      RLS_ST_RX_HOLD: begin
        state_next = RLS_ST_RX_HOLD;
      end
      default: begin
        state_next = RLS_ST_OFF;
      end
    endcase
    // Host stop overrides everything and switches modes
    if (stop_req) begin
      state_next = RLS_ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RLS_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timer loads first timer entering low power, second timer entering receive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmr_reg <= 16'h0000;
      rxto_cnt_reg <= 16'h0000;
    end else if (state_next != state_reg) begin
      if (state_next == RLS_ST_RX) begin
        tmr_reg <= t2_reg;
        rxto_cnt_reg <= rxto_reg;
      end else if (rxto_exit && (tmr_reg != 16'h0000)) begin
        // Sleep covers first timer plus the rest of the second timer
        tmr_reg <= 16'(tmr1_reg + tmr_reg - 16'h0001);
        rxto_cnt_reg <= 16'h0000;
      end else begin
        tmr_reg <= tmr1_reg;
        rxto_cnt_reg <= 16'h0000;
      end
    end else if (tick) begin
      if (tmr_reg != 16'h0000) begin
        tmr_reg <= tmr_reg - 16'h0001;
      end
      if (rxto_cnt_reg != 16'h0000) begin
        rxto_cnt_reg <= rxto_cnt_reg - 16'h0001;
      end
    end
  end

  // A preamble inside the window disarms the receive timeout
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preamble_seen_reg <= 1'b0;
    end else if (state_reg != RLS_ST_RX) begin
      preamble_seen_reg <= 1'b0;
    end else if (ev_rise.preamble) begin
      preamble_seen_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Radio mode outputs
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_on <= 1'b0;
      rc_osc_only <= 1'b0;
      seq_active <= 1'b0;
    end else begin
      rx_on <= (state_next == RLS_ST_RX) || (state_next == RLS_ST_RX_HOLD);
      rc_osc_only <= (state_next == RLS_ST_IDLE) && cfg_reg[RLS_CFG_IDLE_DEPTH];
      seq_active <= (state_next == RLS_ST_IDLE) || (state_next == RLS_ST_STANDBY)
                 || (state_next == RLS_ST_RX);
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic listening;
  assign listening = (state_reg != RLS_ST_OFF);
  assign irq_set = {tmr_done && (state_reg == RLS_ST_IDLE),
                    listening && ev_rise.payload,
                    listening && ev_rise.sync,
                    listening && ev_rise.preamble};
  assign irq_clr = (reg_wr && (reg_addr == RLS_ADDR_IRQ_STAT)) ? reg_wdata[3:0] : 4'h0;

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // ****************************************************************
  // Event pin mapping: two-bit code per pin, pin 4 needs select bit
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_pins <= 5'h00;
    end else begin
      event_pins[0] <= (pinmap_reg[1:0] == RLS_MAP_CRC_PASS) && ev_sync_reg.crc;
      event_pins[1] <= (pinmap_reg[3:2] == RLS_MAP_FIFO) && ev_sync_reg.fifo_threshold;
      event_pins[2] <= (pinmap_reg[5:4] == RLS_MAP_SYNC) && ev_sync_reg.sync;
      event_pins[3] <= (pinmap_reg[7:6] == RLS_MAP_FIFO) && ev_sync_reg.fifo_drained;
      event_pins[4] <= (pinmap_reg[9:8] == RLS_MAP_PREAMBLE)
                    && pinmap_reg[RLS_PIN_PREAMBLE_SEL] && ev_sync_reg.preamble;
    end
  end

  // ****************************************************************
  // Read port: data one cycle after the read strobe, zero when unmapped
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == RLS_ADDR_CFG) begin
      reg_rdata <= {7'h00, cfg_reg};
    end else if (reg_addr == RLS_ADDR_TMR1) begin
      reg_rdata <= tmr1_reg;
    end else if (reg_addr == RLS_ADDR_T2) begin
      reg_rdata <= t2_reg;
    end else if (reg_addr == RLS_ADDR_RXTO) begin
      reg_rdata <= rxto_reg;
    end else if (reg_addr == RLS_ADDR_STATE) begin
      reg_rdata <= {13'h0000, state_reg};
    end else if (reg_addr == RLS_ADDR_IRQ_STAT) begin
      reg_rdata <= {12'h000, irq_stat_reg};
    end else if (reg_addr == RLS_ADDR_IRQ_MASK) begin
      reg_rdata <= {12'h000, irq_mask_reg};
    end else if (reg_addr == RLS_ADDR_PINMAP) begin
      reg_rdata <= {5'h00, pinmap_reg};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : rls_sequencer

`default_nettype wire
